// *** rtl/nand_host.v ***
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "nand_host_consts.vh"
// Host controller driving the flash bus pins cycle by cycle.
module nand_host #(
   parameter DATA_W   = 16,
   parameter PWR_WAIT = `PWR_WAIT_CYC
) (
   input  wire              clock,
   input  wire              rst,
   input  wire [3:0]        regAddr,
   input  wire [31:0]       regWdata,
   input  wire              regWrite,
   input  wire              regRead,
   output reg  [31:0]       regRdata,
   output reg               chipSel_n,
   output reg               cmd_latch_en,
   output reg               addr_latch_en,
   output reg               wrStrobe_n,
   output reg               rdStrobe_n,
   output reg               writeProt_n,
   output reg  [DATA_W-1:0] ioOut,
   output reg  [DATA_W-1:0] ioOe,
   input  wire [DATA_W-1:0] ioIn,
   input  wire              rdy_busy_n
);
   // ****************************************************
   // Overview
   // ****************************************************
   // One operation per control write, taken only when idle.
   // Operation codes: command, address, data write, data read.
   // Each flash bus cycle: strobe low four clocks, high four.
   // Address operation repeats the cycle three times in a row.
   // Pins are registered, so they trail the state by one clock.
   // Trade-off: one extra clock of latency for glitch-free pins.
   //
   // Walk of one write cycle, counted from the control write:
   //   c0  control write taken, state moves to strobe-low
   //   c2  chip select low, latch enable up, strobe low
   //   c6  strobe back high, device latches the bus here
   //   c10 chip select released unless keep-selected is set
   //
   // Walk of one read cycle, counted the same way:
   //   c2  read strobe falls, device starts driving the bus
   //   c5  bus sampled into the read data register
   //   c6  read strobe rises, host keeps the bus released
   //
   // Limitations a user must know:
   //   Control and write-data writes while busy are dropped, not queued; address writes still land.
   //   Software must poll the busy bit between operations.
   //   Ready line is only sampled, never waited on here.
   //   Strobe widths are fixed by the timing constants.
   //   Write protect level is chosen per operation.
   //   Upper lanes are only driven for data writes.
   //
   // Hazard: the ready line comes from off-chip; one flop
   // stage keeps the status read from seeing a changing level.
   // ****************************************************
   // State
   // ****************************************************
   localparam [3:0] S_PWR   = 4'b0001;
   localparam [3:0] S_IDLE  = 4'b0010;
   localparam [3:0] S_LOW   = 4'b0100;
   localparam [3:0] S_HIGH  = 4'b1000;
   localparam [7:0] CNT_LO  = `STROBE_LOW_CYC;
   localparam [7:0] CNT_HI  = `STROBE_HIGH_CYC;

   reg  [3:0]        state_reg;
   reg  [15:0]       pwr_reg;
   reg  [7:0]        cnt_reg;
   reg  [1:0]        op_reg;
   reg  [1:0]        addrIdx_reg;
   reg  [24:0]       addr_reg;
   reg  [DATA_W-1:0] wdata_reg;
   reg  [DATA_W-1:0] rdata_reg;
   reg               ceHold_reg;
   reg               rdySync_reg;
   wire              busy;
   wire [7:0]        addrByte;
   wire              start;

   assign busy  = (state_reg != S_IDLE);
   assign start = regWrite && (regAddr == `REG_CTRL) && (state_reg == S_IDLE);

   // Address byte per cycle; bit 8 belongs to the pointer command
   assign addrByte = (addrIdx_reg == 2'h0) ? addr_reg[7:0] :
                     (addrIdx_reg == 2'h1) ? addr_reg[16:9] :
                                             addr_reg[24:17];

   // ****************************************************
   // Sequencer
   // ****************************************************
   // Control and write-data writes arriving while busy are dropped; address writes still land; software polls status first
   always @(posedge clock)
   begin
      if (rst)
      begin
         state_reg   <= S_PWR;
         pwr_reg     <= 16'h0000;
         cnt_reg     <= 8'h00;
         op_reg      <= 2'h0;
         addrIdx_reg <= 2'h0;
         addr_reg    <= 25'h0000000;
         wdata_reg   <= {DATA_W{1'b0}};
         rdata_reg   <= {DATA_W{1'b0}};
         ceHold_reg  <= 1'b0;
         writeProt_n <= 1'b0;
         rdySync_reg <= 1'b0;
      end
      else
      begin
         rdySync_reg <= rdy_busy_n;           // Low means some chip busy
         if (regWrite && regAddr == `REG_ADDR)
            addr_reg <= regWdata[24:0];
         if (regWrite && regAddr == `REG_WDATA && !busy)
            wdata_reg <= regWdata[DATA_W-1:0];
         if (start)
         begin
            writeProt_n <= regWdata[`CTRL_WP_BIT];
            ceHold_reg  <= regWdata[`CTRL_CE_BIT];   // Keep selected after cycle
         end
         case (state_reg)
            S_PWR:
            begin
               // Strobes held high while the chip recovers
               if (pwr_reg == PWR_WAIT - 1)
                  state_reg <= S_IDLE;
               else
                  pwr_reg <= pwr_reg + 16'h0001;
            end
            S_IDLE:
               if (start)
               begin
                  op_reg      <= regWdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
                  addrIdx_reg <= 2'h0;
                  cnt_reg     <= 8'h00;
                  state_reg   <= S_LOW;
               end
            S_LOW:
               if (cnt_reg == CNT_LO - 1)
               begin
                  cnt_reg   <= 8'h00;
                  state_reg <= S_HIGH;
                  if (op_reg == `OP_READ)
                     rdata_reg <= ioIn;
               end
               else
                  cnt_reg <= cnt_reg + 8'h01;
            S_HIGH:
               if (cnt_reg == CNT_HI - 1)
               begin
                  cnt_reg <= 8'h00;
                  if (op_reg == `OP_ADDR && addrIdx_reg != 2'h2)
                  begin
                     addrIdx_reg <= addrIdx_reg + 2'h1;
                     state_reg   <= S_LOW;
                  end
                  else
                     state_reg <= S_IDLE;
               end
               else
                  cnt_reg <= cnt_reg + 8'h01;
            default:
               state_reg <= S_PWR;
         endcase
      end
   end

   // ****************************************************
   // Pin drive
   // ****************************************************
   // Registered pins; latch enables exclusive by construction
   always @(posedge clock)
   begin
      if (rst)
      begin
         chipSel_n     <= 1'b1;
         cmd_latch_en  <= 1'b0;
         addr_latch_en <= 1'b0;
         wrStrobe_n    <= 1'b1;
         rdStrobe_n    <= 1'b1;
         ioOut         <= {DATA_W{1'b0}};
         ioOe          <= {DATA_W{1'b0}};
      end
      else
      begin
         chipSel_n     <= !(state_reg == S_LOW || state_reg == S_HIGH || ceHold_reg);
         cmd_latch_en  <= (state_reg != S_IDLE && state_reg != S_PWR && op_reg == `OP_CMD);
         addr_latch_en <= (state_reg != S_IDLE && state_reg != S_PWR && op_reg == `OP_ADDR);
         wrStrobe_n    <= !(state_reg == S_LOW && op_reg != `OP_READ);
         rdStrobe_n    <= !(state_reg == S_LOW && op_reg == `OP_READ);
         if (op_reg == `OP_ADDR)
            ioOut <= {{(DATA_W-8){1'b0}}, addrByte};
         else if (op_reg == `OP_CMD)
            ioOut <= {{(DATA_W-8){1'b0}}, wdata_reg[7:0]};
         else
            ioOut <= wdata_reg;
         if ((state_reg == S_LOW || state_reg == S_HIGH) && op_reg != `OP_READ)
            ioOe <= (op_reg == `OP_WRITE) ? {DATA_W{1'b1}} :
                    {{(DATA_W-8){1'b0}}, 8'hFF};
         else
            ioOe <= {DATA_W{1'b0}};                    // Float for device drive
      end
   end

   // ****************************************************
   // Register read port
   // ****************************************************
   // Data one cycle after the read strobe, zero for unmapped offsets
   always @(posedge clock)
   begin
      if (rst)
         regRdata <= 32'h00000000;
      else if (regRead)
         case (regAddr)
            `REG_ADDR:   regRdata <= {7'h00, addr_reg};
            `REG_WDATA:  regRdata <= {{(32-DATA_W){1'b0}}, wdata_reg};
            `REG_RDATA:  regRdata <= {{(32-DATA_W){1'b0}}, rdata_reg};
            `REG_STATUS: regRdata <= {29'h0, (state_reg == S_PWR), rdySync_reg, busy};
            default:     regRdata <= 32'h00000000;
         endcase
      else
         regRdata <= 32'h00000000;
   end
endmodule // nand_host

// *** inc/nand_host_consts.vh ***
// Operation
// - Upper lanes carry data only
// - Wait 10 us after power-up
// - Hold write protect low during power transitions
// - Shared ready/busy low means someone busy
// - Command cycle: select, cmd high, addr low
// - Addresses sent as three cycles
// - Address cycle: select, addr high, cmd low
// - Data cycle: both latch enables low
`ifndef NAND_HOST_CONSTS_VH
`define NAND_HOST_CONSTS_VH
// Register offsets (word index on the plain port)
`define REG_CTRL        4'h0
`define REG_ADDR        4'h1
`define REG_WDATA       4'h2
`define REG_RDATA       4'h3
`define REG_STATUS      4'h4
// Control register fields
`define CTRL_OP_LSB     0
`define CTRL_OP_MSB     1
`define CTRL_WP_BIT     4
`define CTRL_CE_BIT     5
`define CTRL_RESET      8'h00
// Operation codes written to the control register
`define OP_CMD          2'h0
`define OP_ADDR         2'h1
`define OP_WRITE        2'h2
`define OP_READ         2'h3
// Status bits
`define ST_BUSY_BIT     0
`define ST_RDY_BIT      1
`define ST_PWR_BIT      2
// Timing
`define CLK_PERIOD_NS   8
`define PWR_WAIT_US     10
`define PWR_WAIT_CYC    ((`PWR_WAIT_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_LOW_CYC  4
`define STROBE_HIGH_CYC 4
`endif

// *** tb/nand_flash_model.sv ***
`timescale 1ns/1ps
// Behavioural flash device: four-word page buffer and array
module nand_flash_model #(parameter BUSY_NS = 200) (
   input  wire logic        chipSel_n, cmd_latch_en, addr_latch_en,
   input  wire logic        wrStrobe_n, rdStrobe_n, writeProt_n,
   input  wire logic [15:0] ioOut,
   output logic      [15:0] ioIn,
   output logic             rdy_busy_n
);
   // Four-word stand-in for page and block geometry
   logic [15:0] pbuf [0:3];
   logic [15:0] arr [0:3];
   logic [15:0] dout = 16'h0000;
   logic [1:0]  col = 2'h0;
   logic [1:0]  nAddr = 2'h0;
   initial rdy_busy_n = 1'b1;
   // New address sequence after each deselect
   always @(posedge chipSel_n) nAddr = 2'h0;
   // Latch on rising write strobe
   always @(posedge wrStrobe_n)
      if (!chipSel_n && rdStrobe_n)
      begin
         if (cmd_latch_en && ioOut[7:0] == 8'h10 && writeProt_n)
         begin
            for (int i = 0; i < 4; i++) arr[i] = pbuf[i];
            rdy_busy_n = 1'b0;
            #BUSY_NS rdy_busy_n = 1'b1;
         end
         else if (addr_latch_en && nAddr != 2'h3) // Extra cycles ignored
         begin
            if (nAddr == 2'h0) col = ioOut[1:0];
            nAddr = nAddr + 2'h1;
         end
         else if (!cmd_latch_en && !addr_latch_en)
         begin
            pbuf[col] = ioOut;
            col = col + 2'h1;
         end
      end
   // Falling read strobe gives next word
   always @(negedge rdStrobe_n)
      if (!chipSel_n)
      begin
         dout = arr[col];
         col = col + 2'h1;
      end
   // Unpulled bus shows inverse when not driven
   assign ioIn = (!chipSel_n && !rdStrobe_n) ? dout : ~dout;
endmodule // nand_flash_model

// *** tb/nand_host_asserts.sv ***
`timescale 1ns/1ps
// Pin protocol checks on the host's flash side
module nand_host_asserts #(parameter DATA_W = 16, parameter PWR_WAIT = 1250) (
   input wire logic              clock, rst, chipSel_n, cmd_latch_en, addr_latch_en,
   input wire logic              wrStrobe_n, rdStrobe_n, writeProt_n,
   input wire logic [DATA_W-1:0] ioOe
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   logic [15:0] cyc;
   // Cycles since reset, saturating
   always @(posedge clock)
      if (rst) cyc <= 16'h0000;
      else if (cyc != 16'hFFFF) cyc <= cyc + 16'h0001;
   a_latch_excl: assert property (!(cmd_latch_en && addr_latch_en))
      else $error("both latch enables high");
   a_strobe_excl: assert property (!(!wrStrobe_n && !rdStrobe_n))
      else $error("both strobes low");
   a_wp_reset: assert property ($fell(rst) |-> !writeProt_n && chipSel_n)
      else $error("bad pins after reset");
   a_pwr_wait: assert property (cyc < PWR_WAIT |-> chipSel_n && wrStrobe_n)
      else $error("bus used during power wait");
   a_cmd_frame: assert property (cmd_latch_en |-> !chipSel_n && rdStrobe_n)
      else $error("command cycle badly framed");
   a_cmd_strobe: assert property ($fell(wrStrobe_n) && cmd_latch_en |->
      (!wrStrobe_n && cmd_latch_en)[*4] ##1 (wrStrobe_n && cmd_latch_en))
      else $error("command strobe wrong");
   a_addr_strobe: assert property ($fell(wrStrobe_n) && addr_latch_en |->
      (!wrStrobe_n && addr_latch_en && !chipSel_n)[*4] ##1 wrStrobe_n)
      else $error("address strobe wrong");
   a_read_frame: assert property (!rdStrobe_n |-> !chipSel_n && ioOe == '0
      && !cmd_latch_en && !addr_latch_en) else $error("read cycle badly framed");
   a_write_drive: assert property (!wrStrobe_n |-> ioOe[7:0] == 8'hFF)
      else $error("low lanes not driven");
   cover property ($fell(rdStrobe_n));
   cover property ($fell(wrStrobe_n) && addr_latch_en);
   cover property ($fell(wrStrobe_n) && cmd_latch_en);
endmodule // nand_host_asserts
bind nand_host nand_host_asserts #(.DATA_W(DATA_W), .PWR_WAIT(PWR_WAIT)) u_chk (.*);

// *** tb/tb_nand_host.sv ***
`timescale 1ns/1ps
module tb_nand_host;
   logic        clock, rst, regWrite, regRead, chipSel_n, cmd_latch_en, addr_latch_en;
   logic        wrStrobe_n, rdStrobe_n, writeProt_n, rdy_busy_n;
   logic [3:0]  regAddr;
   logic [31:0] regWdata, regRdata, v;
   logic [15:0] ioOut, ioOe, ioIn;
   int          errors, comparisons;
   nand_host #(.PWR_WAIT(8)) i_nand_host (.*);
   nand_flash_model i_nand_flash_model (.*);
   task check(input logic [31:0] seen, exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task test_done;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock); regWrite <= 1'b1; regAddr <= a; regWdata <= d;
      @(posedge clock); regWrite <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input logic [3:0] a);
      @(posedge clock); regRead <= 1'b1; regAddr <= a;
      @(posedge clock); regRead <= 1'b0;
      @(negedge clock); v = regRdata;
   endtask
   task waitFor(input logic [31:0] m, x);
      for (int n = 0; n < 300; n++) begin rd(4'h4); if ((v & m) === x) return; end
      errors++;
      test_done;
   endtask
   task op(input logic [31:0] ctrl, d);
      wr(4'h2, d); wr(4'h0, ctrl); waitFor(32'h1, 32'h0);
   endtask
   task t_power;
      rd(4'h4); check(v[2], 1'b1);
      check({chipSel_n, writeProt_n, wrStrobe_n}, 3'b101);
      waitFor(32'h4, 32'h0); $display("t_power done");
   endtask
   task t_program;
      wr(4'h1, 32'h2); rd(4'h1); check(v, 32'h2);
      op(32'h1, 0); op(32'h2, 32'hA5C3); op(32'h2, 32'h5A3C);
      op(32'h10, 32'h10); rd(4'h4); check(v[1], 1'b0);
      waitFor(32'h2, 32'h2); op(32'h1, 0); op(32'h3, 0);
      rd(4'h3); check(v[15:0], 16'hA5C3);
      op(32'h3, 0); rd(4'h3); check(v[15:0], 16'h5A3C);
      $display("t_program done");
   endtask
   // Write protect low: program command must leave the array alone
   task t_protect;
      op(32'h1, 0); op(32'h2, 32'h1111); op(32'h0, 32'h10);
      rd(4'h4); check(v[1], 1'b1);
      op(32'h1, 0); op(32'h3, 0); rd(4'h3); check(v[15:0], 16'hA5C3);
      rd(4'hF); check(v, 32'h0); $display("t_protect done");
   endtask
   // Mid-run reset: pins idle, power wait runs again
   task t_reset;
      @(posedge clock); rst <= 1'b1;
      repeat (2) @(posedge clock); rst <= 1'b0;
      rd(4'h4); check({v[2], v[0]}, 2'b11);
      check({chipSel_n, writeProt_n, wrStrobe_n}, 3'b101);
      waitFor(32'h5, 32'h0); $display("t_reset done");
   endtask
   initial begin clock = 1'b0; forever #4 clock = ~clock; end
   initial
   begin
      rst = 1'b1; regWrite = 1'b0; regRead = 1'b0; regAddr = 4'h0; regWdata = 32'h0;
      errors = 0; comparisons = 0;
      repeat (3) @(posedge clock);
      rst <= 1'b0;
      t_power; t_program; t_protect; t_reset;
      test_done;
   end
endmodule // tb_nand_host
